// ---- common/gpdq_regs.vh ----
`ifndef GPDQ_REGS_VH
`define GPDQ_REGS_VH

////////////////////////////////////////////////////////////////////////////////
// Register indices; the byte address of each register is four times its index.
`define GPDQ_IDX_W                  15
`define GPDQ_PORT_A_PIN_DATA        15'h6fc0
`define GPDQ_PORT_A_BIT_SET         15'h6fc2
`define GPDQ_PORT_A_BIT_CLEAR       15'h6fc4
`define GPDQ_PORT_A_BIT_INVERT      15'h6fc6
`define GPDQ_PORT_B_PIN_DATA        15'h6fc8
`define GPDQ_PORT_B_BIT_SET         15'h6fca
`define GPDQ_PORT_B_BIT_CLEAR       15'h6fcc
`define GPDQ_PORT_B_BIT_INVERT      15'h6fce
`define GPDQ_ANALOG_PORT_PIN_DATA   15'h6fd8
`define GPDQ_ANALOG_PORT_BIT_SET    15'h6fda
`define GPDQ_ANALOG_PORT_BIT_CLEAR  15'h6fdc
`define GPDQ_ANALOG_PORT_BIT_INVERT 15'h6fde

// Configuration registers that steer direction, function and qualification.
`define GPDQ_PORT_A_QUALIFY_PERIOD      15'h6f80
`define GPDQ_PORT_A_QUALIFY_SELECT_LOW  15'h6f82
`define GPDQ_PORT_A_QUALIFY_SELECT_HIGH 15'h6f84
`define GPDQ_PORT_A_PERIPH_SELECT       15'h6f86
`define GPDQ_PORT_A_DIRECTION           15'h6f8a
`define GPDQ_PORT_B_QUALIFY_PERIOD      15'h6f90
`define GPDQ_PORT_B_QUALIFY_SELECT_LOW  15'h6f92
`define GPDQ_PORT_B_QUALIFY_SELECT_HIGH 15'h6f94
`define GPDQ_PORT_B_PERIPH_SELECT       15'h6f96
`define GPDQ_PORT_B_DIRECTION           15'h6f9a
`define GPDQ_ANALOG_PORT_PERIPH_SELECT  15'h6fb6
`define GPDQ_ANALOG_PORT_DIRECTION      15'h6fba

////////////////////////////////////////////////////////////////////////////////
// Latch update operations.
`define GPDQ_OP_LOAD   2'h0
`define GPDQ_OP_SET    2'h1
`define GPDQ_OP_CLEAR  2'h2
`define GPDQ_OP_INVERT 2'h3

// Qualifier select codes, two bits per pin.
`define GPDQ_QSEL_SYNC  2'h0
`define GPDQ_QSEL_THREE 2'h1
`define GPDQ_QSEL_SIX   2'h2
`define GPDQ_QSEL_ASYNC 2'h3

// Reset values.
`define GPDQ_RST_ZERO   32'h0000_0000
`define GPDQ_RST_QSEL   64'h0000_0000_0000_0000

// Pins per port, pins per sampling-period group and width of a group's period field.
`define GPDQ_PORT_A_PINS  32
`define GPDQ_PORT_B_PINS  13
`define GPDQ_ANALOG_PINS  16
`define GPDQ_GROUP_PINS   8
`define GPDQ_PERIOD_W     8

`endif

// ---- logic/gpdq_tick.v ----
`timescale 1ns/1ps
`include "gpdq_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Sample strobe for one eight-pin group: every clock when the period is zero,
// otherwise once every twice-the-period clocks.
module gpdq_tick
(
  input wire                      hclk,
  input wire                      hresetn,
  input wire [`GPDQ_PERIOD_W-1:0] period,
  output wire                     tick
);

  reg  [`GPDQ_PERIOD_W:0] cnt_q;
  wire [`GPDQ_PERIOD_W:0] last;

  // Last count of a period; a period lowered to a last count the counter has passed ends the running one at once.
  assign last = (period == {`GPDQ_PERIOD_W{1'b0}}) ? {(`GPDQ_PERIOD_W+1){1'b0}} :
                ({period, 1'b0} - {{`GPDQ_PERIOD_W{1'b0}}, 1'b1});
  assign tick = (cnt_q >= last);

  // Free-running period counter.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cnt_q <= {(`GPDQ_PERIOD_W+1){1'b0}};
    else if (tick)
      cnt_q <= {(`GPDQ_PERIOD_W+1){1'b0}};
    else
      cnt_q <= cnt_q + {{`GPDQ_PERIOD_W{1'b0}}, 1'b1};
  end

endmodule

// ---- logic/gpdq_qual.v ----
`timescale 1ns/1ps
`include "gpdq_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// One pin's input path: two-stage synchroniser, then either a plain pass or a
// three- or six-sample window; peripherals may instead take the raw pin.
module gpdq_qual
(
  input wire       hclk,
  input wire       hresetn,
  input wire       pin_raw,
  input wire       tick,
  input wire [1:0] qsel,
  input wire       periph_sel,
  output reg       qual_level,
  output wire      periph_level
);

  reg       meta_q;
  reg       sync_q;
  reg [4:0] hist_q;
  wire      three_ok;
  wire      six_ok;

  // The current sample and its predecessors must all agree.
  assign three_ok = (sync_q == hist_q[0]) && (sync_q == hist_q[1]);
  assign six_ok   = three_ok && (hist_q[4:1] == {4{sync_q}});

  // The window history is not cleared on a mode change; old samples flush out.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_q     <= 1'b0;
      sync_q     <= 1'b0;
      hist_q     <= 5'h00;
      qual_level <= 1'b0;
    end
    else
    begin
      meta_q <= pin_raw;
      sync_q <= meta_q;
      if (tick)
        hist_q <= {hist_q[3:0], sync_q};
      case (qsel)
        `GPDQ_QSEL_THREE:
        begin
          if (tick && three_ok)
            qual_level <= sync_q;
        end
        `GPDQ_QSEL_SIX:
        begin
          if (tick && six_ok)
            qual_level <= sync_q;
        end
        default:
          qual_level <= sync_q;
      endcase
    end
  end

  // Asynchronous mode only bypasses for peripheral inputs, never for GPIO.
  assign periph_level = (periph_sel && (qsel == `GPDQ_QSEL_ASYNC)) ?
                        pin_raw : qual_level;

endmodule

// ---- logic/gpdq_top.v ----
// The implementer's own choice: the AHB-Lite slave port.
`timescale 1ns/1ps
`include "gpdq_regs.vh"

module gpdq_top
#(
  parameter PA = `GPDQ_PORT_A_PINS,
  parameter PB = `GPDQ_PORT_B_PINS,
  parameter PN = `GPDQ_ANALOG_PINS
)
(
  input wire           hclk,
  input wire           hresetn,
  input wire           hsel,
  input wire [31:0]    haddr,
  input wire [1:0]     htrans,
  input wire           hwrite,
  input wire [2:0]     hsize,
  input wire [31:0]    hwdata,
  input wire           hready,
  output wire          hreadyout,
  output wire          hresp,
  output reg [31:0]    hrdata,
  input wire [PA-1:0]  port_a_pin_in,
  output wire [PA-1:0] port_a_pin_out,
  output wire [PA-1:0] port_a_pin_oe_n,
  output wire [PA-1:0] port_a_periph_in,
  input wire [PB-1:0]  port_b_pin_in,
  output wire [PB-1:0] port_b_pin_out,
  output wire [PB-1:0] port_b_pin_oe_n,
  output wire [PB-1:0] port_b_periph_in,
  input wire [PN-1:0]  analog_pin_in,
  output wire [PN-1:0] analog_pin_out,
  output wire [PN-1:0] analog_pin_oe_n
);

  localparam GA = (PA + `GPDQ_GROUP_PINS - 1) / `GPDQ_GROUP_PINS;
  localparam GB = (PB + `GPDQ_GROUP_PINS - 1) / `GPDQ_GROUP_PINS;
  localparam ZB = 32 - PB;
  localparam ZN = 32 - PN;

  ////////////////////////////////////////////////////////////////////////////////
  // Applies one of the four latch operations to a full word.
  function [31:0] gpdq_apply;
    input [31:0] cur;
    input [31:0] wd;
    input [1:0]  op;
    begin
      case (op)
        `GPDQ_OP_SET:    gpdq_apply = cur | wd;
        `GPDQ_OP_CLEAR:  gpdq_apply = cur & ~wd;
        `GPDQ_OP_INVERT: gpdq_apply = cur ^ wd;
        default:         gpdq_apply = wd;
      endcase
    end
  endfunction

  // Widens a port value to a bus word with zeros above.
  function [31:0] gpdq_word;
    input [31:0] val;
    input integer width;
    integer i;
    begin
      gpdq_word = 32'h0000_0000;
      for (i = 0; i < 32; i = i + 1)
        if (i < width)
          gpdq_word[i] = val[i];
    end
  endfunction

  // True when an index falls on one of the four latch registers of a port.
  function gpdq_hit;
    input [`GPDQ_IDX_W-1:0] idx;
    input [`GPDQ_IDX_W-1:0] base;
    begin
      gpdq_hit = (idx[`GPDQ_IDX_W-1:3] == base[`GPDQ_IDX_W-1:3]) && !idx[0];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////////
  // Bus phase state.
  reg                    wr_pend_q;
  reg                    rd_first_q;
  reg [`GPDQ_IDX_W-1:0]  addr_q;
  wire                   accept;

  // Configuration and latch state.
  reg [PA-1:0]  lat_a_q;
  reg [PB-1:0]  lat_b_q;
  reg [PN-1:0]  lat_n_q;
  reg [PA-1:0]  dir_a_q;
  reg [PB-1:0]  dir_b_q;
  reg [PN-1:0]  dir_n_q;
  reg [PA-1:0]  per_a_q;
  reg [PB-1:0]  per_b_q;
  reg [PN-1:0]  per_n_q;
  reg [63:0]    qsel_a_q;
  reg [63:0]    qsel_b_q;
  reg [31:0]    prd_a_q;
  reg [31:0]    prd_b_q;

  // Analog pin synchroniser.
  reg [PN-1:0]  meta_n_q;
  reg [PN-1:0]  sync_n_q;

  // Write decode.
  reg           wr_a;
  reg           wr_b;
  reg           wr_n;
  reg [1:0]     wr_op;
  reg [31:0]    rd_mux;
  wire [31:0]   nxt_a;
  wire [31:0]   nxt_b;
  wire [31:0]   nxt_n;

  // Qualified levels and sample strobes.
  wire [PA-1:0] qual_a;
  wire [PB-1:0] qual_b;
  wire [GA-1:0] tick_a;
  wire [GB-1:0] tick_b;

  ////////////////////////////////////////////////////////////////////////////////
  // Address phase capture; reads take one wait state, writes none.
  assign accept    = hsel && htrans[1] && hready;
  assign hreadyout = ~rd_first_q;
  assign hresp     = 1'b0;

  // A read address is taken at the edge that commits the previous write.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_q  <= 1'b0;
      rd_first_q <= 1'b0;
      addr_q     <= {`GPDQ_IDX_W{1'b0}};
      hrdata     <= 32'h0000_0000;
    end
    else
    begin
      wr_pend_q  <= accept && hwrite;
      rd_first_q <= accept && !hwrite;
      if (accept)
        addr_q <= haddr[`GPDQ_IDX_W+1:2];
      if (rd_first_q)
        hrdata <= rd_mux;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Decodes which latch a write targets; index bits 2:1 above the data register
  // are the load, set, clear and invert codes themselves.
  always @*
  begin
    wr_a  = wr_pend_q && gpdq_hit(addr_q, `GPDQ_PORT_A_PIN_DATA);
    wr_b  = wr_pend_q && gpdq_hit(addr_q, `GPDQ_PORT_B_PIN_DATA);
    wr_n  = wr_pend_q && gpdq_hit(addr_q, `GPDQ_ANALOG_PORT_PIN_DATA);
    wr_op = addr_q[2:1];
  end

  // Next latch values, bit n of the word to pin n of the port.
  assign nxt_a = gpdq_apply(gpdq_word(lat_a_q, PA), hwdata, wr_op);
  assign nxt_b = gpdq_apply({{ZB{1'b0}}, lat_b_q}, hwdata, wr_op);
  assign nxt_n = gpdq_apply({{ZN{1'b0}}, lat_n_q}, hwdata, wr_op);

  // Output latches update whatever the pin direction or function.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      lat_a_q <= {PA{1'b0}};
      lat_b_q <= {PB{1'b0}};
      lat_n_q <= {PN{1'b0}};
    end
    else
    begin
      if (wr_a)
        lat_a_q <= nxt_a[PA-1:0];
      if (wr_b)
        lat_b_q <= nxt_b[PB-1:0];
      if (wr_n)
        lat_n_q <= nxt_n[PN-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Direction, function and qualification configuration.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dir_a_q  <= {PA{1'b0}};
      dir_b_q  <= {PB{1'b0}};
      dir_n_q  <= {PN{1'b0}};
      per_a_q  <= {PA{1'b0}};
      per_b_q  <= {PB{1'b0}};
      per_n_q  <= {PN{1'b0}};
      qsel_a_q <= `GPDQ_RST_QSEL;
      qsel_b_q <= `GPDQ_RST_QSEL;
      prd_a_q  <= `GPDQ_RST_ZERO;
      prd_b_q  <= `GPDQ_RST_ZERO;
    end
    else if (wr_pend_q)
    begin
      case (addr_q)
        `GPDQ_PORT_A_DIRECTION:           dir_a_q <= hwdata[PA-1:0];
        `GPDQ_PORT_B_DIRECTION:           dir_b_q <= hwdata[PB-1:0];
        `GPDQ_ANALOG_PORT_DIRECTION:      dir_n_q <= hwdata[PN-1:0];
        `GPDQ_PORT_A_PERIPH_SELECT:       per_a_q <= hwdata[PA-1:0];
        `GPDQ_PORT_B_PERIPH_SELECT:       per_b_q <= hwdata[PB-1:0];
        `GPDQ_ANALOG_PORT_PERIPH_SELECT:  per_n_q <= hwdata[PN-1:0];
        `GPDQ_PORT_A_QUALIFY_SELECT_LOW:  qsel_a_q[31:0] <= hwdata;
        `GPDQ_PORT_A_QUALIFY_SELECT_HIGH: qsel_a_q[63:32] <= hwdata;
        `GPDQ_PORT_B_QUALIFY_SELECT_LOW:  qsel_b_q[31:0] <= hwdata;
        `GPDQ_PORT_B_QUALIFY_SELECT_HIGH: qsel_b_q[63:32] <= hwdata;
        `GPDQ_PORT_A_QUALIFY_PERIOD:      prd_a_q <= hwdata;
        `GPDQ_PORT_B_QUALIFY_PERIOD:      prd_b_q <= hwdata;
        default:                          prd_a_q <= prd_a_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Sample strobes, one per eight-pin group.
  genvar g;
  generate
    for (g = 0; g < GA; g = g + 1)
    begin : ga_tick
      gpdq_tick u_tick
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .period  (prd_a_q[8*g+7:8*g]),
        .tick    (tick_a[g])
      );
    end
    for (g = 0; g < GB; g = g + 1)
    begin : gb_tick
      gpdq_tick u_tick
      (
        .hclk    (hclk),
        .hresetn (hresetn),
        .period  (prd_b_q[8*g+7:8*g]),
        .tick    (tick_b[g])
      );
    end
  endgenerate

  // Per-pin qualifiers for the two digital ports.
  generate
    for (g = 0; g < PA; g = g + 1)
    begin : ga_pin
      gpdq_qual u_qual
      (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .pin_raw      (port_a_pin_in[g]),
        .tick         (tick_a[g/`GPDQ_GROUP_PINS]),
        .qsel         (qsel_a_q[2*g+1:2*g]),
        .periph_sel   (per_a_q[g]),
        .qual_level   (qual_a[g]),
        .periph_level (port_a_periph_in[g])
      );
    end
    for (g = 0; g < PB; g = g + 1)
    begin : gb_pin
      gpdq_qual u_qual
      (
        .hclk         (hclk),
        .hresetn      (hresetn),
        .pin_raw      (port_b_pin_in[g]),
        .tick         (tick_b[g/`GPDQ_GROUP_PINS]),
        .qsel         (qsel_b_q[2*g+1:2*g]),
        .periph_sel   (per_b_q[g]),
        .qual_level   (qual_b[g]),
        .periph_level (port_b_periph_in[g])
      );
    end
  endgenerate

  // Analog-capable pins are only synchronised.
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      meta_n_q <= {PN{1'b0}};
      sync_n_q <= {PN{1'b0}};
    end
    else
    begin
      meta_n_q <= analog_pin_in;
      sync_n_q <= meta_n_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Read data: data registers show the pin, bit registers read zero.
  always @*
  begin
    case (addr_q)
      `GPDQ_PORT_A_PIN_DATA:            rd_mux = gpdq_word(qual_a, PA);
      `GPDQ_PORT_B_PIN_DATA:            rd_mux = {{ZB{1'b0}}, qual_b};
      `GPDQ_ANALOG_PORT_PIN_DATA:       rd_mux = {{ZN{1'b0}}, sync_n_q};
      `GPDQ_PORT_A_DIRECTION:           rd_mux = gpdq_word(dir_a_q, PA);
      `GPDQ_PORT_B_DIRECTION:           rd_mux = {{ZB{1'b0}}, dir_b_q};
      `GPDQ_ANALOG_PORT_DIRECTION:      rd_mux = {{ZN{1'b0}}, dir_n_q};
      `GPDQ_PORT_A_PERIPH_SELECT:       rd_mux = gpdq_word(per_a_q, PA);
      `GPDQ_PORT_B_PERIPH_SELECT:       rd_mux = {{ZB{1'b0}}, per_b_q};
      `GPDQ_ANALOG_PORT_PERIPH_SELECT:  rd_mux = {{ZN{1'b0}}, per_n_q};
      `GPDQ_PORT_A_QUALIFY_SELECT_LOW:  rd_mux = qsel_a_q[31:0];
      `GPDQ_PORT_A_QUALIFY_SELECT_HIGH: rd_mux = qsel_a_q[63:32];
      `GPDQ_PORT_B_QUALIFY_SELECT_LOW:  rd_mux = qsel_b_q[31:0];
      `GPDQ_PORT_B_QUALIFY_SELECT_HIGH: rd_mux = qsel_b_q[63:32];
      `GPDQ_PORT_A_QUALIFY_PERIOD:      rd_mux = prd_a_q;
      `GPDQ_PORT_B_QUALIFY_PERIOD:      rd_mux = prd_b_q;
      default:                          rd_mux = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Pins drive the latch only as general purpose outputs.
  assign port_a_pin_out  = lat_a_q;
  assign port_b_pin_out  = lat_b_q;
  assign analog_pin_out  = lat_n_q;
  assign port_a_pin_oe_n = ~(dir_a_q & ~per_a_q);
  assign port_b_pin_oe_n = ~(dir_b_q & ~per_b_q);
  assign analog_pin_oe_n = ~(dir_n_q & ~per_n_q);

endmodule

// ---- dv/gpdq_chk_asserts.sv ----
`timescale 1ns/1ps
`include "gpdq_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Watches the bus timing and the port A latches of the top module.
module gpdq_chk
#(
  parameter PA = 32
)
(
  input wire          hclk,
  input wire          hresetn,
  input wire          hsel,
  input wire [31:0]   haddr,
  input wire [1:0]    htrans,
  input wire          hwrite,
  input wire [31:0]   hwdata,
  input wire          hready,
  input wire          hreadyout,
  input wire          hresp,
  input wire [31:0]   hrdata,
  input wire [PA-1:0] port_a_pin_out,
  input wire [PA-1:0] port_a_pin_oe_n
);
  wire        take_d;
  reg         wr_q;
  reg         rd_q;
  reg  [14:0] idx_q;
  wire        bit_wr_d;

  // Tracks the data phase of each accepted transfer and its register index.
  assign take_d = hsel & htrans[1] & hready;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_q  <= 1'b0;
      rd_q  <= 1'b0;
      idx_q <= 15'h0000;
    end
    else if (hready)
    begin
      wr_q  <= take_d & hwrite;
      rd_q  <= take_d & ~hwrite;
      idx_q <= take_d ? haddr[16:2] : idx_q;
    end
  end
  assign bit_wr_d = wr_q & hready;

  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Each latch operation lands on the edge that ends the write data phase.
  a_data_load: assert property (bit_wr_d && idx_q == `GPDQ_PORT_A_PIN_DATA |=>
    port_a_pin_out == $past(hwdata[PA-1:0])) else $error("data write did not load");
  a_set_high: assert property (bit_wr_d && idx_q == `GPDQ_PORT_A_BIT_SET |=>
    port_a_pin_out == ($past(port_a_pin_out) | $past(hwdata[PA-1:0])))
    else $error("set write wrong");
  a_clear_low: assert property (bit_wr_d && idx_q == `GPDQ_PORT_A_BIT_CLEAR |=>
    port_a_pin_out == ($past(port_a_pin_out) & ~$past(hwdata[PA-1:0])))
    else $error("clear write wrong");
  a_invert_flip: assert property (bit_wr_d && idx_q == `GPDQ_PORT_A_BIT_INVERT |=>
    port_a_pin_out == ($past(port_a_pin_out) ^ $past(hwdata[PA-1:0])))
    else $error("invert write wrong");
  a_latch_hold: assert property (!bit_wr_d |=> $stable(port_a_pin_out))
    else $error("latch moved without a write");
  a_strobe_zero: assert property (rd_q && hreadyout && (idx_q == `GPDQ_PORT_A_BIT_SET ||
    idx_q == `GPDQ_PORT_A_BIT_CLEAR || idx_q == `GPDQ_PORT_A_BIT_INVERT) |->
    hrdata == 32'h0000_0000) else $error("strobe register read not zero");
  a_read_wait: assert property (take_d && !hwrite |=> !hreadyout ##1 hreadyout)
    else $error("read wait state wrong");
  a_write_nowait: assert property (take_d && hwrite |=> hreadyout && !hresp)
    else $error("write not zero wait");
  a_reset_clear: assert property ($rose(hresetn) |->
    port_a_pin_out == 0 && &port_a_pin_oe_n) else $error("latch not cleared by reset");

  // Main traffic seen.
  c_read: cover property (rd_q && hreadyout);
  c_invert: cover property (bit_wr_d && idx_q == `GPDQ_PORT_A_BIT_INVERT);
  c_drive: cover property (port_a_pin_oe_n == 0);
endmodule

bind gpdq_top gpdq_chk #(.PA(PA)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .port_a_pin_out(port_a_pin_out),
  .port_a_pin_oe_n(port_a_pin_oe_n));

// ---- dv/gpdq_pins.sv ----
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Board side of one port: a driven pin follows its latch, a released pin the board.
module gpdq_pins
#(
  parameter W = 32
)
(
  input wire [W-1:0]  pin_out,
  input wire [W-1:0]  oe_n,
  input wire [W-1:0]  board,
  output wire [W-1:0] pin_in
);
  // Released pins never show the latch, so a stale drive cannot pass for a match.
  assign pin_in = (pin_out & ~oe_n) | (board & oe_n);
endmodule

// ---- dv/gpdq_top_tb.sv ----
`timescale 1ns/1ps
`include "gpdq_regs.vh"

module gpdq_top_tb;
  localparam [14:0] A_DAT = `GPDQ_PORT_A_PIN_DATA;
  localparam [14:0] A_DIR = `GPDQ_PORT_A_DIRECTION;
  localparam [14:0] A_QSL = `GPDQ_PORT_A_QUALIFY_SELECT_LOW;
  reg         hclk;
  reg         hresetn;
  reg         hsel;
  reg  [31:0] haddr;
  reg  [1:0]  htrans;
  reg         hwrite;
  reg  [31:0] hwdata;
  wire        hready;
  wire        hresp;
  wire [31:0] hrdata;
  wire [31:0] pa_in, pa_out, pa_oe_n, pa_per;
  wire [12:0] pb_in, pb_out, pb_oe_n, pb_per;
  wire [15:0] pn_in, pn_out, pn_oe_n;
  reg  [31:0] ea;
  reg  [12:0] eb;
  reg  [15:0] en;
  reg  [31:0] rd, lat;
  integer     errors, compares, i;
  reg  [1:0]  ops [0:6] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h1, 2'h2, 2'h3};
  reg  [31:0] vals [0:6] = '{32'hA5A5_0F0F, 32'h0000_00F0, 32'h0500_0001, 32'hFFFF_0000,
                             32'h0000_0000, 32'h0000_0000, 32'h0000_0000};

  gpdq_top dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready),
    .hresp(hresp), .hrdata(hrdata), .port_a_pin_in(pa_in), .port_a_pin_out(pa_out),
    .port_a_pin_oe_n(pa_oe_n), .port_a_periph_in(pa_per), .port_b_pin_in(pb_in),
    .port_b_pin_out(pb_out), .port_b_pin_oe_n(pb_oe_n), .port_b_periph_in(pb_per),
    .analog_pin_in(pn_in), .analog_pin_out(pn_out), .analog_pin_oe_n(pn_oe_n));
  gpdq_pins #(.W(32)) u_pa (.pin_out(pa_out), .oe_n(pa_oe_n), .board(ea), .pin_in(pa_in));
  gpdq_pins #(.W(13)) u_pb (.pin_out(pb_out), .oe_n(pb_oe_n), .board(eb), .pin_in(pb_in));
  gpdq_pins #(.W(16)) u_pn (.pin_out(pn_out), .oe_n(pn_oe_n), .board(en), .pin_in(pn_in));

  // Free-running bus clock, 4 ns period.
  always #2 hclk = ~hclk;

  ////////////////////////////////////////////////////////////////////////////////
  // Prints the counts and the verdict, then stops the run.
  task wrap_up;
  begin
    $display("errors=%0d compares=%0d", errors, compares);
    if (errors == 0 && compares > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  end
  endtask

  // Compares one 32-bit result.
  task cmp(input [31:0] got, input [31:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      errors = errors + 1;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  end
  endtask

  // Lets n edges pass and settles just after the last one.
  task step(input integer n);
  begin
    repeat (n) @(posedge hclk);
    #1;
  end
  endtask

  // One single AHB-Lite transfer; hready and read data are taken at rising edges.
  task ahb(input w, input [14:0] ix, input [31:0] wd, output [31:0] r);
  begin
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {15'h0000, ix, 2'h0};
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1) @(posedge hclk);
    r = hrdata;
  end
  endtask

  task wr(input [14:0] ix, input [31:0] d);
    reg [31:0] dummy;
  begin
    ahb(1'b1, ix, d, dummy);
  end
  endtask

  task rdc(input [14:0] ix, input [31:0] e);
  begin
    ahb(1'b0, ix, 32'h0000_0000, rd);
    cmp(rd, e);
  end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Hang guard, far beyond the two hundred or so cycles the tests take.
  initial
  begin
    #40000;
    errors = errors + 1;
    $display("watchdog expired");
    wrap_up;
  end

  // Test sequence.
  initial
  begin
    errors = 0;
    compares = 0;
    hclk = 1'b0;
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0000_0000;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = 32'h0000_0000;
    ea = 32'h1234_5678;
    eb = 13'h0000;
    en = 16'h0000;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    step(4);
    cmp(pa_out, 32'h0000_0000);
    cmp(pa_oe_n, 32'hFFFF_FFFF);
    cmp(32'(pb_oe_n), 32'h0000_1FFF);
    cmp(32'(pn_oe_n), 32'h0000_FFFF);
    rdc(A_DAT, 32'h1234_5678);
    for (i = 1; i < 4; i = i + 1)
      rdc(A_DAT + 15'(2 * i), 32'h0000_0000);
    rdc(15'h0100, 32'h0000_0000);
    $display("test reset done");
    lat = 32'h0000_0000;
    for (i = 0; i < 7; i = i + 1)
    begin
      wr(A_DAT + 15'(2 * ops[i]), vals[i]);
      case (ops[i])
        2'h0: lat = vals[i];
        2'h1: lat = lat | vals[i];
        2'h2: lat = lat & ~vals[i];
        default: lat = lat ^ vals[i];
      endcase
      step(1);
      cmp(pa_out, lat);
    end
    rdc(A_DAT, 32'h1234_5678);
    $display("test latch ops done");
    wr(A_DIR, 32'hFFFF_FFFF);
    rdc(A_DIR, 32'hFFFF_FFFF);
    step(1);
    cmp(pa_oe_n, 32'h0000_0000);
    wr(A_DAT, 32'h0F0F_F0F0);
    rdc(A_DAT, lat);
    cmp(pa_out, 32'h0F0F_F0F0);
    step(4);
    rdc(A_DAT, 32'h0F0F_F0F0);
    wr(A_DIR, 32'h0000_0000);
    $display("test drive done");
    ea <= 32'h0000_0000;
    wr(`GPDQ_PORT_A_QUALIFY_PERIOD, 32'h0000_0100);
    wr(A_QSL, 32'h0002_0001);
    step(8);
    for (i = 0; i < 20; i = i + 1)
    begin
      ea <= (i < 2) ? 32'h0000_0101 : ((i < 8) ? 32'h0000_0100 : 32'h0000_0000);
      step(1);
      cmp(pa_per & 32'h0000_0101, 32'h0000_0000);
    end
    ea <= 32'h0000_0101;
    step(8);
    cmp(pa_per & 32'h0000_0101, 32'h0000_0001);
    step(22);
    rdc(A_DAT, 32'h0000_0101);
    $display("test window done");
    wr(`GPDQ_PORT_A_PERIPH_SELECT, 32'h0000_0004);
    wr(A_QSL, 32'h0002_00F1);
    step(1);
    ea <= 32'h0000_010D;
    #1;
    cmp(pa_per & 32'h0000_000C, 32'h0000_0004);
    step(4);
    cmp(pa_per & 32'h0000_000C, 32'h0000_000C);
    rdc(A_DAT, 32'h0000_010D);
    $display("test async done");
    wr(`GPDQ_PORT_B_BIT_SET, 32'hFFFF_F001);
    wr(`GPDQ_ANALOG_PORT_BIT_INVERT, 32'h0001_8000);
    step(1);
    cmp(32'(pb_out), 32'h0000_1001);
    cmp(32'(pn_out), 32'h0000_8000);
    eb <= 13'h1555;
    en <= 16'hA5A5;
    step(4);
    rdc(`GPDQ_PORT_B_PIN_DATA, 32'h0000_1555);
    rdc(`GPDQ_ANALOG_PORT_PIN_DATA, 32'h0000_A5A5);
    cmp(32'(pb_per), 32'h0000_1555);
    wr(`GPDQ_ANALOG_PORT_DIRECTION, 32'h0000_FFFF);
    step(1);
    cmp(32'(pn_oe_n), 32'h0000_0000);
    step(3);
    rdc(`GPDQ_ANALOG_PORT_PIN_DATA, 32'h0000_8000);
    $display("test ports done");
    wrap_up;
  end
endmodule
